// [rtl/oit_pkg.sv]
package oit_pkg;
   localparam int unsigned ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_MODE  = 10'h0d8;
   localparam logic [9:0] IDX_COUNT = 10'h0d9;
   localparam logic [9:0] IDX_IRQ   = 10'h0da;
   // Field positions
   localparam int unsigned MODE_EN_BIT  = 7;
   localparam int unsigned MODE_RATE_LO = 4;
   localparam int unsigned IRQ_FLAG_BIT = 0;
   localparam int unsigned IRQ_IEN_BIT  = 1;
   // Reset values and the count top value
   localparam logic [7:0] MODE_RST  = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] PRE_RST   = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hff;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       count_enable;
      logic [2:0] prescale_select;
      logic [3:0] unused;
   } oit_mode_t;

   typedef struct packed {
      logic overflow_irq_enable;
      logic overflow_request_flag;
   } oit_irq_t;

   typedef enum logic [1:0] {
      OIT_IDLE = 2'b01,
      OIT_RESP = 2'b10
   } oit_bus_st_t;
endpackage

// [rtl/oit_prescaler.sv]
`timescale 1ns/1ps
module oit_prescaler
   import oit_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Control
   input  wire logic       enable,
   input  wire logic [2:0] prescale_select,
   // Count tick
   output logic            tick
);
   logic [7:0] div_ff;
   logic [7:0] nxt_div;
   logic [7:0] mask;

   // Divider is held at zero while stopped so a restart gives a full first period
   always_comb
   begin
      mask    = 8'hff >> prescale_select;
      nxt_div = enable ? div_ff + 8'h01 : PRE_RST;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_ff <= PRE_RST;
      else
         div_ff <= nxt_div;
   end

   assign tick = enable && ((div_ff & mask) == mask);
endmodule

// [rtl/oit_timer.sv]
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module oit_timer
   import oit_pkg::*;
(
   // Clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // Write address channel
   input  wire logic [oit_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   // Write data channel
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // Write response channel
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // Read address channel
   input  wire logic [oit_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   // Read data channel
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // System
   input  wire logic                         green_mode,
   output logic                              timeout_pulse,
   output logic                              wake_request,
   output logic                              irq_request
);
   import oit_pkg::*;

   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
      logic [9:0] idx;
      idx = addr[ADDR_W-1:2];
      if (idx == IDX_MODE)
         reg_sel = 2'h1;
      else if (idx == IDX_COUNT)
         reg_sel = 2'h2;
      else if (idx == IDX_IRQ)
         reg_sel = 2'h3;
      else
         reg_sel = 2'h0;
   endfunction

   oit_bus_st_t wr_st_ff, nxt_wr_st, rd_st_ff, nxt_rd_st;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   oit_mode_t   mode_ff, nxt_mode;
   oit_irq_t    irq_ff, nxt_irq;
   logic [7:0]  count_ff, nxt_count;
   logic        tout_ff, nxt_tout, wake_ff, nxt_wake;
   logic        wr_go, rd_go, mode_wr, count_wr, irq_wr, tick, ovf;
   logic [1:0]  wsel, rsel;

   oit_prescaler u_pre (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .enable          (mode_ff.count_enable),
      .prescale_select (mode_ff.prescale_select),
      .tick            (tick)
   );

   // Address and data are taken together; waiting for both keeps one write in flight
   assign s_axi_awready = (wr_st_ff == OIT_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = (rd_st_ff == OIT_IDLE);
   assign s_axi_bvalid  = (wr_st_ff == OIT_RESP);
   assign s_axi_rvalid  = (rd_st_ff == OIT_RESP);
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign timeout_pulse = tout_ff;
   assign wake_request  = wake_ff;
   assign irq_request   = irq_ff.overflow_request_flag && irq_ff.overflow_irq_enable;

   always_comb
   begin
      wr_go    = s_axi_awready;
      rd_go    = s_axi_arvalid && s_axi_arready;
      wsel     = reg_sel(s_axi_awaddr);
      rsel     = reg_sel(s_axi_araddr);
      mode_wr  = wr_go && s_axi_wstrb[0] && (wsel == 2'h1);
      count_wr = wr_go && s_axi_wstrb[0] && (wsel == 2'h2);
      irq_wr   = wr_go && s_axi_wstrb[0] && (wsel == 2'h3);
      ovf      = tick && (count_ff == COUNT_TOP);
      // Bus state
      nxt_wr_st = wr_st_ff;
      nxt_bresp = bresp_ff;
      case (wr_st_ff)
         OIT_IDLE:
         begin
            if (wr_go)
            begin
               nxt_wr_st = OIT_RESP;
               nxt_bresp = (wsel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end
         end
         OIT_RESP:
         begin
            if (s_axi_bready)
               nxt_wr_st = OIT_IDLE;
         end
         default: nxt_wr_st = OIT_IDLE;
      endcase
      nxt_rd_st = rd_st_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      case (rd_st_ff)
         OIT_IDLE:
         begin
            if (rd_go)
            begin
               nxt_rd_st = OIT_RESP;
               nxt_rresp = (rsel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
               case (rsel)
                  2'h1:    nxt_rdata = {24'h000000, mode_ff.count_enable, mode_ff.prescale_select, 4'h0};
                  2'h2:    nxt_rdata = {24'h000000, count_ff};
                  2'h3:    nxt_rdata = {30'h0, irq_ff};
                  default: nxt_rdata = 32'h00000000;
               endcase
            end
         end
         OIT_RESP:
         begin
            if (s_axi_rready)
               nxt_rd_st = OIT_IDLE;
         end
         default: nxt_rd_st = OIT_IDLE;
      endcase
      // Timer state
      nxt_mode = mode_ff;
      if (mode_wr)
      begin
         nxt_mode.count_enable    = s_axi_wdata[MODE_EN_BIT];
         nxt_mode.prescale_select = s_axi_wdata[MODE_RATE_LO+:3];
      end
      nxt_mode.unused = 4'h0;
      if (count_wr)
         nxt_count = s_axi_wdata[7:0];
      else if (tick)
         nxt_count = count_ff + 8'h01;
      else
         nxt_count = count_ff;
      nxt_irq = irq_ff;
      if (irq_wr)
      begin
         nxt_irq.overflow_irq_enable = s_axi_wdata[IRQ_IEN_BIT];
         // Writing zero clears the flag; a one leaves it alone
         if (!s_axi_wdata[IRQ_FLAG_BIT])
            nxt_irq.overflow_request_flag = 1'b0;
      end
      // An overflow in the clearing cycle is kept
      if (ovf)
         nxt_irq.overflow_request_flag = 1'b1;
      nxt_tout = ovf;
      nxt_wake = ovf && mode_ff.count_enable && green_mode;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_st_ff <= OIT_IDLE;
         rd_st_ff <= OIT_IDLE;
         bresp_ff <= RESP_OKAY;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h00000000;
         mode_ff  <= MODE_RST;
         count_ff <= COUNT_RST;
         irq_ff   <= 2'h0;
         tout_ff  <= 1'b0;
         wake_ff  <= 1'b0;
      end
      else
      begin
         wr_st_ff <= nxt_wr_st;
         rd_st_ff <= nxt_rd_st;
         bresp_ff <= nxt_bresp;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         mode_ff  <= nxt_mode;
         count_ff <= nxt_count;
         irq_ff   <= nxt_irq;
         tout_ff  <= nxt_tout;
         wake_ff  <= nxt_wake;
      end
   end

   property p_wrap;
      @(posedge aclk) disable iff (!aresetn)
      (tick && count_ff == 8'hff && !count_wr) |=> (count_ff == 8'h00) && timeout_pulse ##1 !timeout_pulse;
   endproperty
   a_wrap: assert property (p_wrap) else $error("Wrap did not reach zero with one time-out");

   property p_keep_counting;
      @(posedge aclk) disable iff (!aresetn)
      timeout_pulse && !$past(mode_wr) |-> mode_ff.count_enable;
   endproperty
   a_keep_counting: assert property (p_keep_counting) else $error("Counter stopped on overflow");

   property p_wake;
      @(posedge aclk) disable iff (!aresetn)
      timeout_pulse |-> (wake_request == $past(green_mode && mode_ff.count_enable));
   endproperty
   a_wake: assert property (p_wake) else $error("Wake request wrong on time-out");

   property p_gate;
      @(posedge aclk) disable iff (!aresetn)
      (!mode_ff.count_enable && !count_wr) |=> $stable(count_ff) && !timeout_pulse;
   endproperty
   a_gate: assert property (p_gate) else $error("Count moved while disabled");

   property p_div2;
      @(posedge aclk) disable iff (!aresetn)
      (tick && mode_ff.prescale_select == 3'h7 && !mode_wr) ##1 !mode_wr |-> !tick ##1 tick;
   endproperty
   a_div2: assert property (p_div2) else $error("Divide by two spacing wrong");

   property p_load;
      @(posedge aclk) disable iff (!aresetn)
      count_wr |=> count_ff == $past(s_axi_wdata[7:0]);
   endproperty
   a_load: assert property (p_load) else $error("Count write not loaded");

   property p_step;
      @(posedge aclk) disable iff (!aresetn)
      (tick && !count_wr) |=> count_ff == $past(count_ff) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("Count did not step by one");

   property p_flag;
      @(posedge aclk) disable iff (!aresetn)
      timeout_pulse |-> irq_ff.overflow_request_flag ##0 (irq_request == irq_ff.overflow_irq_enable);
   endproperty
   a_flag: assert property (p_flag) else $error("Overflow flag or request wrong");
endmodule

// [test/oit_timer_bench.sv]
`timescale 1ns/1ps
module oit_timer_bench;
   import oit_pkg::*;
   localparam logic [11:0] A_MODE = {IDX_MODE, 2'b00};
   localparam logic [11:0] A_CNT  = {IDX_COUNT, 2'b00};
   localparam logic [11:0] A_IRQ  = {IDX_IRQ, 2'b00};
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv, q;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, green_mode;
   logic        awready, wready, bvalid, arready, rvalid, timeout_pulse, wake_request, irq_request;
   int          mismatches, checks_done, cyc, t0, n;
   logic [11:0] row_a [5] = '{A_MODE, A_MODE, A_CNT, A_IRQ, A_IRQ};
   logic [7:0]  row_d [5] = '{8'h7f, 8'h2a, 8'ha5, 8'h02, 8'h00};
   logic [7:0]  row_q [5] = '{8'h70, 8'h20, 8'ha5, 8'h02, 8'h00};

   oit_timer i_dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .green_mode(green_mode), .timeout_pulse(timeout_pulse),
      .wake_request(wake_request), .irq_request(irq_request)
   );

   initial
      aclk = 1'b0;
   always #5 aclk = ~aclk;
   always @(posedge aclk)
      cyc <= cyc + 1;

   task test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every polling loop goes through here, so a silent design ends the run instead of hanging it
   task step();
      if (n > 2000)
      begin
         mismatches++;
         test_done();
      end
      n++;
      @(negedge aclk);
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      n = 0;
      step();
      while (awready !== 1'b1)
         step();
      t0 = cyc;
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      step();
      while (bvalid !== 1'b1)
         step();
      resp = bresp;
      @(posedge aclk);
   endtask

   task rd(input logic [11:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      n = 0;
      step();
      while (arready !== 1'b1)
         step();
      @(posedge aclk);
      arvalid <= 1'b0;
      step();
      while (rvalid !== 1'b1)
         step();
      rdv  = rdata;
      resp = rresp;
      @(posedge aclk);
   endtask

   initial
   begin
      {awaddr, araddr, wdata, awvalid, wvalid, arvalid, green_mode} = '0;
      wstrb = 4'h1;
      // Response ready held high: AXI allows it and the bench never needs to stall
      {bready, rready} = 2'b11;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         rd(A_MODE + 12'(4 * i));
         chk(rdv, 32'h0);
      end
      for (int i = 0; i < 5; i++)
      begin
         wr(row_a[i], row_d[i]);
         chk(resp, RESP_OKAY);
         rd(row_a[i]);
         chk(rdv, row_q[i]);
      end
      wr(12'h36c, 8'h80);
      chk(resp, RESP_SLVERR);
      rd(12'h000);
      chk(resp, RESP_SLVERR);
      rd(A_MODE);
      chk(rdv, 32'h20);
      // Each rate code, with irq enable and green mode varied, so the flag is seen without the irq
      for (int c = 0; c < 8; c++)
      begin
         green_mode <= c[1];
         wr(A_MODE, 8'h00);
         wr(A_IRQ, 8'h00);
         wr(A_MODE, {1'b0, 3'(c), 4'h0});
         wr(A_CNT, 8'hfd);
         wr(A_IRQ, {6'h0, c[0], 1'b0});
         wr(A_MODE, {1'b1, 3'(c), 4'h0});
         n = 0;
         step();
         while (timeout_pulse !== 1'b1)
            step();
         chk(32'((cyc - t0) >= 3 * (256 >> c) && (cyc - t0) <= 3 * (256 >> c) + 3), 32'h1);
         chk(wake_request, c[1]);
         chk(irq_request, c[0]);
         @(negedge aclk);
         chk(timeout_pulse, 32'h0);
         // Back to a rising edge, so the read request is not launched mid-cycle
         @(posedge aclk);
         rd(A_IRQ);
         chk(rdv, {c[0], 1'b1});
      end
      // Flag from the last wrap: a written one keeps it, and the masked line stays low
      wr(A_IRQ, 8'h01);
      rd(A_IRQ);
      chk(rdv, 32'h1);
      chk(irq_request, 32'h0);
      wr(A_IRQ, 8'h02);
      rd(A_IRQ);
      chk(rdv, 32'h2);
      rd(A_CNT);
      q = rdv;
      rd(A_CNT);
      chk(32'(rdv !== q), 32'h1);
      wr(A_MODE, 8'h70);
      rd(A_CNT);
      q = rdv;
      repeat (10) @(posedge aclk);
      rd(A_CNT);
      chk(rdv, q);
      // Byte lane zero off: acknowledged, count untouched
      wstrb <= 4'h0;
      wr(A_CNT, 8'h5a);
      chk(resp, RESP_OKAY);
      wstrb <= 4'h1;
      rd(A_CNT);
      chk(rdv, q);
      // Reset in mid-run with the timer counting and the irq armed
      wr(A_MODE, 8'hf0);
      wr(A_IRQ, 8'h02);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({timeout_pulse, wake_request, irq_request}, 32'h0);
      @(posedge aclk);
      for (int i = 0; i < 3; i++)
      begin
         rd(A_MODE + 12'(4 * i));
         chk(rdv, 32'h0);
      end
      test_done();
   end
endmodule
